// *** flash_write_status_reporting.sv ***
// Function
// - host reads status at the address of the byte being programmed
// - host reads erase status inside a sector selected for erasure
// - polling bit may settle early; take valid data on the next read
// - ready/busy is open-drain; system supplies pull-up, wires may share
// - host does two back-to-back reads, equal toggle bit means finished
// - toggling with timeout bit high: recheck; still toggling is failure
// - host restarts toggle check from double read after leaving
// - after toggle stops, host takes array data from next read
// - host re-reads polling bit even after timeout bit seen high
// - reset command writes F0 anywhere, returns device to array reads
module flash_write_status_reporting #(
    parameter int ADDR_W = flash_status_pkg::ADDR_W,
    parameter int DATA_W = flash_status_pkg::DATA_W
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // user command port
    input wire logic start_i,
    input wire logic [1:0] op_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic expect_d7_i,
    input wire logic abort_i,
    output logic busy_o,
    output logic done_o,
    output logic pass_o,
    output logic fail_o,
    output logic [DATA_W-1:0] data_o,
    output logic erase_suspended_o,
    output logic sector_toggling_o,
    output logic device_busy_o,
    // flash pins
    output logic ce_n_o,
    output logic oe_n_o,
    output logic we_n_o,
    output logic [ADDR_W-1:0] flash_addr_o,
    input wire logic [DATA_W-1:0] flash_data_i,
    output logic [DATA_W-1:0] flash_data_o,
    output logic flash_data_oe_o,
    input wire logic ready_busy_n_i
);
    typedef enum logic [7:0] {
        S_IDLE = 8'b0000_0001,
        S_READ_A = 8'b0000_0010,
        S_READ_B = 8'b0000_0100,
        S_READ_C = 8'b0000_1000,
        S_READ_D = 8'b0001_0000,
        S_FINAL = 8'b0010_0000,
        S_RESET = 8'b0100_0000,
        S_DONE = 8'b1000_0000
    } poll_state_t;

    localparam int P7 = flash_status_pkg::DATA_POLL_BIT_POS;
    localparam int P6 = flash_status_pkg::TOGGLE_BIT_ONE_POS;
    localparam int P5 = flash_status_pkg::TIMEOUT_FAILURE_BIT_POS;
    localparam int P2 = flash_status_pkg::SECTOR_TOGGLE_BIT_POS;

    poll_state_t state_q, state_d;
    logic [1:0] op_q;
    logic [ADDR_W-1:0] addr_q;
    logic expect_q;
    logic [DATA_W-1:0] prev_q, data_q;
    logic pass_q, fail_q, susp_q, stog_q;

    logic bus_done;
    logic [DATA_W-1:0] rdata;

    wire logic is_toggle = (op_q == flash_status_pkg::OP_TOGGLE);
    wire logic in_read = (state_q == S_READ_A) || (state_q == S_READ_B) ||
        (state_q == S_READ_C) || (state_q == S_READ_D) ||
        (state_q == S_FINAL);
    wire logic in_write = (state_q == S_RESET);
    wire logic bus_req = in_read || in_write;
    wire logic [ADDR_W-1:0] bus_addr =
        in_write ? flash_status_pkg::RESET_CMD_ADDR : addr_q;
    wire logic poll_true = (rdata[P7] == expect_q);
    wire logic tog_same = (rdata[P6] == prev_q[P6]);
    wire logic stog_diff = (rdata[P2] != prev_q[P2]);
    wire logic timed_out = rdata[P5];
    // abort lets the host leave; a new start redoes the double read
    wire logic stop_early = abort_i && bus_done &&
        (state_q == S_READ_A || state_q == S_READ_B);
    // events that commit a result
    wire logic start_taken = (state_q == S_IDLE) && start_i;
    wire logic final_taken = (state_q == S_FINAL) && bus_done;
    wire logic reset_taken = (state_q == S_RESET) && bus_done;
    wire logic pair_taken = (state_q == S_READ_B) && bus_done;

    always_comb begin
        state_d = state_q;
        case (state_q)
            S_IDLE: begin
                if (start_i) begin
                    if (op_i == flash_status_pkg::OP_RESET) state_d = S_RESET;
                    else state_d = S_READ_A;
                end
            end
            S_READ_A: begin
                if (stop_early) state_d = S_IDLE;
                else if (bus_done && is_toggle) state_d = S_READ_B;
                else if (bus_done && poll_true) state_d = S_FINAL;
                else if (bus_done && timed_out) state_d = S_READ_C;
            end
            S_READ_B: begin
                if (stop_early) state_d = S_IDLE;
                else if (bus_done && tog_same) state_d = S_FINAL;
                else if (bus_done && timed_out) state_d = S_READ_C;
            end
            S_READ_C: begin
                if (bus_done && is_toggle) state_d = S_READ_D;
                else if (bus_done && poll_true) state_d = S_FINAL;
                else if (bus_done) state_d = S_RESET;
            end
            S_READ_D: begin
                if (bus_done && tog_same) state_d = S_FINAL;
                else if (bus_done) state_d = S_RESET;
            end
            S_FINAL: if (bus_done) state_d = S_DONE;
            S_RESET: if (bus_done) state_d = S_DONE;
            S_DONE: state_d = S_IDLE;
            default: state_d = S_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= S_IDLE;
            op_q <= 2'h0;
            addr_q <= '0;
            expect_q <= 1'b0;
            prev_q <= '0;
        end else begin
            state_q <= state_d;
            if (start_taken) begin
                op_q <= op_i;
                // status address: program target or erased sector
                addr_q <= addr_i;
                // erase polls expect 1 on the polling bit
                expect_q <= expect_d7_i;
            end
            if (bus_done && in_read) prev_q <= rdata;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            data_q <= '0;
            pass_q <= 1'b0;
            fail_q <= 1'b0;
            susp_q <= 1'b0;
            stog_q <= 1'b0;
        end else begin
            if (start_taken) begin
                pass_q <= 1'b0;
                fail_q <= 1'b0;
                // compare flags of an older check are stale now
                susp_q <= 1'b0;
                stog_q <= 1'b0;
            end
            // array data only from the read after status settled
            if (final_taken) begin
                data_q <= rdata;
                pass_q <= 1'b1;
            end
            if (reset_taken) begin
                fail_q <= (op_q != flash_status_pkg::OP_RESET);
            end
            // steady toggle bit with moving sector bit: erase paused
            if (pair_taken) begin
                stog_q <= stog_diff;
                susp_q <= tog_same && stog_diff;
            end
        end
    end

    flash_bus_cycle #(
        .ADDR_W(ADDR_W),
        .DATA_W(DATA_W)
    ) u_bus (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .req_i(bus_req),
        .write_i(in_write),
        .addr_i(bus_addr),
        .wdata_i(flash_status_pkg::RESET_CMD_DATA),
        .done_o(bus_done),
        .rdata_o(rdata),
        .ce_n_o(ce_n_o),
        .oe_n_o(oe_n_o),
        .we_n_o(we_n_o),
        .addr_o(flash_addr_o),
        .data_i(flash_data_i),
        .data_o(flash_data_o),
        .data_oe_o(flash_data_oe_o)
    );

    assign busy_o = (state_q != S_IDLE);
    assign done_o = (state_q == S_DONE);
    assign pass_o = pass_q;
    assign fail_o = fail_q;
    assign data_o = data_q;
    assign erase_suspended_o = susp_q;
    assign sector_toggling_o = stog_q;
    // pin is open-drain, pulled up outside; low means busy
    assign device_busy_o = !ready_busy_n_i;
endmodule

// *** flash_status_pkg.sv ***
package flash_status_pkg;

    // flash bus widths
    localparam int ADDR_W = 22;
    localparam int DATA_W = 8;

    // status bit positions on the data lines
    localparam int DATA_POLL_BIT_POS = 7;
    localparam int TOGGLE_BIT_ONE_POS = 6;
    localparam int TIMEOUT_FAILURE_BIT_POS = 5;
    localparam int ERASE_WINDOW_BIT_POS = 3;
    localparam int SECTOR_TOGGLE_BIT_POS = 2;

    // reset command data, written at any address
    localparam logic [7:0] RESET_CMD_DATA = 8'hF0;
    localparam logic [21:0] RESET_CMD_ADDR = 22'h000000;

    // bus timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int READ_STROBE_NS = 100;
    localparam int WRITE_STROBE_NS = 100;
    localparam int READ_STROBE_CYC =
        (READ_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_STROBE_CYC =
        (WRITE_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_CNT_W = 4;

    // user operations
    localparam logic [1:0] OP_DATA_POLL = 2'h0;
    localparam logic [1:0] OP_TOGGLE = 2'h1;
    localparam logic [1:0] OP_RESET = 2'h2;

endpackage

// *** flash_bus_cycle.sv ***
module flash_bus_cycle #(
    parameter int ADDR_W = flash_status_pkg::ADDR_W,
    parameter int DATA_W = flash_status_pkg::DATA_W
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // cycle request
    input wire logic req_i,
    input wire logic write_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    output logic done_o,
    output logic [DATA_W-1:0] rdata_o,
    // flash pins
    output logic ce_n_o,
    output logic oe_n_o,
    output logic we_n_o,
    output logic [ADDR_W-1:0] addr_o,
    input wire logic [DATA_W-1:0] data_i,
    output logic [DATA_W-1:0] data_o,
    output logic data_oe_o
);
    typedef enum logic [3:0] {
        B_IDLE = 4'b0001,
        B_SETUP = 4'b0010,
        B_STROBE = 4'b0100,
        B_HOLD = 4'b1000
    } bus_state_t;

    localparam logic [3:0] RD_CYC =
        4'(flash_status_pkg::READ_STROBE_CYC);
    localparam logic [3:0] WR_CYC =
        4'(flash_status_pkg::WRITE_STROBE_CYC);

    bus_state_t state_q, state_d;
    logic write_q;
    logic [3:0] cnt_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] wdata_q, rdata_q;

    wire logic accept = (state_q == B_IDLE) && req_i;
    wire logic strobe_last = (state_q == B_STROBE) && (cnt_q == 4'h1);
    wire logic in_cycle = (state_q != B_IDLE);

    always_comb begin
        state_d = state_q;
        case (state_q)
            B_IDLE: if (req_i) state_d = B_SETUP;
            B_SETUP: state_d = B_STROBE;
            B_STROBE: if (strobe_last) state_d = B_HOLD;
            B_HOLD: state_d = B_IDLE;
            default: state_d = B_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= B_IDLE;
            write_q <= 1'b0;
            cnt_q <= 4'h0;
            addr_q <= '0;
            wdata_q <= '0;
            rdata_q <= '0;
        end else begin
            state_q <= state_d;
            if (accept) begin
                write_q <= write_i;
                addr_q <= addr_i;
                wdata_q <= wdata_i;
            end
            if (state_q == B_SETUP) cnt_q <= write_q ? WR_CYC : RD_CYC;
            else if (state_q == B_STROBE) cnt_q <= cnt_q - 4'h1;
            // sample at the end of the output-enable strobe
            if (strobe_last && !write_q) rdata_q <= data_i;
        end
    end

    assign done_o = (state_q == B_HOLD);
    assign rdata_o = rdata_q;
    assign ce_n_o = !in_cycle;
    assign oe_n_o = !((state_q == B_STROBE) && !write_q);
    assign we_n_o = !((state_q == B_STROBE) && write_q);
    assign addr_o = addr_q;
    assign data_o = wdata_q;
    assign data_oe_o = in_cycle && write_q;
endmodule

// *** flash_write_status_reporting_asserts.sv ***
module flash_write_status_reporting_chk #(
    parameter int ADDR_W = 22,
    parameter int DATA_W = 8
) (
    // watched ports
    input wire logic clk_i, reset_n_i, start_i, busy_o, done_o,
    input wire logic pass_o, fail_o, ce_n_o, oe_n_o, we_n_o,
    input wire logic flash_data_oe_o, device_busy_o, ready_busy_n_i,
    input wire logic [ADDR_W-1:0] flash_addr_o,
    input wire logic [DATA_W-1:0] flash_data_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    strobe_excl_a: assert property (oe_n_o || we_n_o)
        else $error("read and write strobes low together");
    read_sel_a: assert property (!oe_n_o
        |-> !ce_n_o && !flash_data_oe_o)
        else $error("read strobe without select or with bus driven");
    oe_pulse_a: assert property ($fell(oe_n_o) |=> oe_n_o && !ce_n_o)
        else $error("read strobe not one cycle with hold");
    addr_hold_a: assert property (!ce_n_o && !$past(ce_n_o)
        |-> $stable(flash_addr_o)) else $error("address moved in cycle");
    reset_cmd_a: assert property (!we_n_o |-> flash_data_oe_o
        && flash_data_o == flash_status_pkg::RESET_CMD_DATA)
        else $error("write strobe without reset data");
    start_ce_a: assert property (start_i && !busy_o
        |=> ce_n_o ##1 !ce_n_o) else $error("start did not open a bus cycle");
    pass_read_a: assert property (done_o && pass_o
        |-> !$past(oe_n_o, 2)) else $error("pass without a final read");
    fail_write_a: assert property (done_o && fail_o
        |-> !$past(we_n_o, 2) && !pass_o) else $error("fail without reset");
    rb_follow_a: assert property (device_busy_o == !ready_busy_n_i)
        else $error("device busy flag wrong");
    done_pulse_a: assert property (done_o |=> !done_o)
        else $error("done longer than one cycle");
    cover property (done_o && pass_o);
    cover property (done_o && fail_o);
    cover property (!we_n_o);
endmodule

bind flash_write_status_reporting flash_write_status_reporting_chk #(
    .ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (.clk_i, .reset_n_i, .start_i,
    .busy_o, .done_o, .pass_o, .fail_o, .ce_n_o, .oe_n_o, .we_n_o,
    .flash_data_oe_o, .device_busy_o, .ready_busy_n_i, .flash_addr_o,
    .flash_data_o);

// *** dev_model.sv ***
module dev_model (
    // flash pins
    input wire logic ce_n_i, oe_n_i, we_n_i,
    input wire logic [21:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] data_o,
    output logic rb_pull_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // modes: 0 array, 1 program, 2 erase, 3 suspended, 4 timed out,
    // 5 protected program target, 6 all erase sectors protected
    int mode = 0;
    int left = 0;
    logic d7 = 1'b0, tog = 1'b0, st = 1'b0, hit_reset = 1'b0;
    logic [7:0] last = 8'h00;
    logic [7:0] stat;
    logic [21:0] raddr = 22'h000000;
    logic wiped = 1'b0;
    logic [5:0] wipe_sec = 6'h00;
    time stop_t = 0;
    always_comb begin
        case (mode)
            1: stat = {(left <= 1) ? d7 : !d7, tog, 6'h00};
            2: stat = {left <= 1, tog, 3'h0, st, 2'h0};
            3: stat = {1'b1, tog, 3'h0, st, 2'h0};
            4: stat = {!d7, tog, 1'b1, 5'h00};
            5: stat = {!d7, tog, 6'h00};
            6: stat = {1'b0, tog, 6'h00};
            default: stat = (wiped && addr_i[21:16] == wipe_sec) ? 8'hFF : 8'h5A;
        endcase
    end
    // released bus shows the inverse of the last byte
    assign data_o = (!ce_n_i && !oe_n_i) ? stat : ~last;
    assign rb_pull_o = mode == 1 || mode == 2 || mode == 4;
    task automatic arm(input int m, input int n, input logic b7);
        mode = m;
        left = n;
        d7 = b7;
        tog = 1'b0;
        hit_reset = 1'b0;
        wiped = 1'b0;
        stop_t = $time + n;
    endtask
    always @(posedge oe_n_i) if (!ce_n_i) begin
        last = stat;
        raddr = addr_i;
        if (mode inside {1, 2, 4, 5, 6}) tog = !tog;
        if (mode inside {2, 3}) st = !st;
        if (mode inside {1, 2}) left--;
        // only the unprotected selected sector is wiped
        if (mode == 2 && left == 0) wiped = 1'b1;
        if (mode inside {1, 2} && left == 0) mode = 0;
        if (mode inside {5, 6} && $time >= stop_t) mode = 0;
    end
    always @(posedge we_n_i) if (!ce_n_i && wdata_i == 8'hF0) begin
        mode = 0;
        hit_reset = 1'b1;
    end
endmodule

// *** flash_write_status_reporting_tb_top.sv ***
module flash_write_status_reporting_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0, reset_n_i = 1'b0, start_i = 1'b0, abort_i = 1'b0;
    logic [1:0] op_i = 2'h0;
    logic [21:0] addr_i = 22'h000000;
    logic expect_d7_i = 1'b0;
    logic busy_o, done_o, pass_o, fail_o, erase_suspended_o;
    logic sector_toggling_o, device_busy_o, ce_n_o, oe_n_o, we_n_o;
    logic flash_data_oe_o, rb_pull;
    logic [21:0] flash_addr_o;
    logic [7:0] data_o, flash_data_o, flash_data_i;
    wire ready_busy_n_i = !rb_pull; // pulled up unless held low
    int bad_count = 0, num_checks = 0, cycles = 0;
    always #50 clk_i = !clk_i;
    flash_write_status_reporting u_flash_write_status_reporting (.clk_i,
        .reset_n_i, .start_i, .op_i, .addr_i, .expect_d7_i, .abort_i,
        .busy_o, .done_o, .pass_o, .fail_o, .data_o, .erase_suspended_o,
        .sector_toggling_o, .device_busy_o, .ce_n_o, .oe_n_o, .we_n_o,
        .flash_addr_o, .flash_data_i, .flash_data_o, .flash_data_oe_o,
        .ready_busy_n_i);
    dev_model u_dev_model (.ce_n_i(ce_n_o), .oe_n_i(oe_n_o),
        .we_n_i(we_n_o), .addr_i(flash_addr_o), .wdata_i(flash_data_o),
        .data_o(flash_data_i), .rb_pull_o(rb_pull));
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic check_flag(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected flag at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task automatic check_val(input logic [21:0] got, input logic [21:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected value at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task automatic run_op(input logic [1:0] op, input logic [21:0] a,
        input logic e7);
        @(negedge clk_i);
        start_i = 1'b1;
        op_i = op;
        addr_i = a;
        expect_d7_i = e7;
        @(negedge clk_i);
        start_i = 1'b0;
        while (done_o !== 1'b1) @(negedge clk_i);
    endtask
    task automatic t_program();
        u_dev_model.arm(1, 3, 1'b1);
        @(negedge clk_i);
        check_flag(device_busy_o, 1'b1);
        run_op(flash_status_pkg::OP_DATA_POLL, 22'h012345, 1'b1);
        check_flag(pass_o, 1'b1);
        check_val(22'(data_o), 22'h00005A);
        check_val(u_dev_model.raddr, 22'h012345);
        check_flag(device_busy_o, 1'b0);
        $display("test program finished");
    endtask
    task automatic t_erase();
        u_dev_model.arm(2, 3, 1'b1);
        u_dev_model.wipe_sec = 6'h23;
        run_op(flash_status_pkg::OP_TOGGLE, 22'h230000, 1'b1);
        check_flag(pass_o, 1'b1);
        check_val(22'(data_o), 22'h0000FF);
        check_flag(erase_suspended_o, 1'b0);
        check_val(u_dev_model.raddr, 22'h230000);
        run_op(flash_status_pkg::OP_DATA_POLL, 22'h240000, 1'b0);
        check_val(22'(data_o), 22'h00005A);
        $display("test erase finished");
    endtask
    task automatic t_protect();
        time t0;
        u_dev_model.arm(5, 1000, 1'b1);
        t0 = $time;
        run_op(flash_status_pkg::OP_TOGGLE, 22'h012345, 1'b1);
        check_flag(pass_o, 1'b1);
        check_val(22'(data_o), 22'h00005A);
        check_flag(($time - t0) >= 1000, 1'b1);
        u_dev_model.arm(6, 100000, 1'b1);
        t0 = $time;
        run_op(flash_status_pkg::OP_TOGGLE, 22'h240000, 1'b1);
        check_flag(pass_o, 1'b1);
        check_val(22'(data_o), 22'h00005A);
        check_flag(($time - t0) >= 100000, 1'b1);
        $display("test protect finished");
    endtask
    task automatic t_abort();
        u_dev_model.arm(2, 6, 1'b1);
        abort_i = 1'b1;
        @(negedge clk_i);
        start_i = 1'b1;
        op_i = flash_status_pkg::OP_TOGGLE;
        addr_i = 22'h230000;
        @(negedge clk_i);
        start_i = 1'b0;
        repeat (6) @(negedge clk_i);
        check_flag(busy_o, 1'b0);
        check_flag(u_dev_model.tog, 1'b1);
        abort_i = 1'b0;
        run_op(flash_status_pkg::OP_TOGGLE, 22'h230000, 1'b1);
        check_flag(pass_o, 1'b1);
        check_flag(u_dev_model.mode == 0, 1'b1);
        $display("test abort finished");
    endtask
    task automatic t_suspend();
        u_dev_model.arm(3, 0, 1'b1);
        run_op(flash_status_pkg::OP_TOGGLE, 22'h230000, 1'b1);
        check_flag(erase_suspended_o, 1'b1);
        check_flag(sector_toggling_o, 1'b1);
        check_flag(device_busy_o, 1'b0);
        run_op(flash_status_pkg::OP_DATA_POLL, 22'h230000, 1'b1);
        check_flag(pass_o, 1'b1);
        $display("test suspend finished");
    endtask
    task automatic t_timeout();
        for (int k = 0; k < 2; k++) begin
            u_dev_model.arm(4, 0, 1'b1);
            run_op(2'(k), 22'h001000, 1'b1);
            check_flag(fail_o, 1'b1);
            check_flag(pass_o, 1'b0);
            check_flag(u_dev_model.hit_reset, 1'b1);
            check_flag(device_busy_o, 1'b0);
        end
        u_dev_model.arm(0, 0, 1'b0);
        run_op(flash_status_pkg::OP_RESET, 22'h000000, 1'b0);
        check_flag(fail_o, 1'b0);
        check_flag(u_dev_model.hit_reset, 1'b1);
        $display("test timeout finished");
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            summarize();
        end
    end
    initial begin
        repeat (4) @(negedge clk_i);
        reset_n_i = 1'b1;
        t_program();
        t_erase();
        t_suspend();
        t_protect();
        t_abort();
        t_timeout();
        summarize();
    end
endmodule
